//--- src/hres_pkg.sv
/*
  Constants, register map and carrier types for the receiver latched
  event status block.
  Assumes one receiver clock and that event sources share that clock.
*/
// Overview of operation
// - color depth change latches status three bit 7
// - set bits hold until their clear bit
// - bits reach a line only when that line's mask enables
// - irregular video clock latches status three bit 6
// - audio kind change latches status three bit 5
// - audio parity failure latches status three bit 4
// - channel 0 rate bits change latches bit 3
// - flat-line sample packet latches status three bit 2
// - link frequency beyond tolerance latches bit 1
// - audio buffer at low threshold latches bit 0
// - mpeg frame checksum failure latches four bit 7
// - product frame checksum failure latches four bit 6
// - audio frame checksum failure latches four bit 5
// - video frame checksum failure latches four bit 4
// - port b integrity expiry latches four bit 3
// - port a integrity expiry latches four bit 2
// - status read-only, reset zero, writes ignored
package hres_pkg;
  localparam int AW = 8;
  localparam int DW = 8;
  localparam int FW = 16;

  // register byte addresses
  localparam logic [AW-1:0] ADDR_STATUS_THREE = 8'h84;
  localparam logic [AW-1:0] ADDR_CLEAR_THREE  = 8'h85;
  localparam logic [AW-1:0] ADDR_MASK1_THREE  = 8'h86;
  localparam logic [AW-1:0] ADDR_MASK2_THREE  = 8'h87;
  localparam logic [AW-1:0] ADDR_STATUS_FOUR  = 8'h89;
  localparam logic [AW-1:0] ADDR_CLEAR_FOUR   = 8'h8A;
  localparam logic [AW-1:0] ADDR_MASK1_FOUR   = 8'h8B;
  localparam logic [AW-1:0] ADDR_MASK2_FOUR   = 8'h8C;
  localparam logic [AW-1:0] ADDR_FREQ_TOL     = 8'h8D;
  localparam logic [AW-1:0] ADDR_LOW_THRESH   = 8'h8E;

  // reset values
  localparam logic [DW-1:0] RST_ZERO       = 8'h00;
  localparam logic [DW-1:0] RST_FREQ_TOL   = 8'h04;
  localparam logic [DW-1:0] RST_LOW_THRESH = 8'h08;
  localparam logic [FW-1:0] RST_FREQ_REF   = 16'h0000;
  // status four bits 1:0 belong to another block and read zero
  localparam logic [DW-1:0] FOUR_LIVE_MASK = 8'hFC;

  // bit positions, status three
  localparam int B3_COLOR_DEPTH = 7;
  localparam int B3_VIDEO_CLOCK = 6;
  localparam int B3_AUDIO_KIND  = 5;
  localparam int B3_PARITY      = 4;
  localparam int B3_SAMPLE_RATE = 3;
  localparam int B3_FLATLINE    = 2;
  localparam int B3_LINK_FREQ   = 1;
  localparam int B3_BUFFER_LOW  = 0;
  // bit positions, status four
  localparam int B4_MPEG_CKS    = 7;
  localparam int B4_PRODUCT_CKS = 6;
  localparam int B4_AUDIO_CKS   = 5;
  localparam int B4_VIDEO_CKS   = 4;
  localparam int B4_PORT_B_EXP  = 3;
  localparam int B4_PORT_A_EXP  = 2;

  // one-cycle event pulses from receiver logic
  typedef struct packed {
    logic video_clock_irregular;
    logic audio_parity_fail;
    logic flatline_packet;
    logic mpeg_frame_checksum;
    logic product_frame_checksum;
    logic audio_frame_checksum;
    logic video_frame_checksum;
    logic port_b_integrity_expiry;
    logic port_a_integrity_expiry;
  } hres_pulse_s;

  // levels whose changes are events
  typedef struct packed {
    logic [2:0] color_depth;
    logic [1:0] audio_kind;
    logic [3:0] sample_rate;
  } hres_level_s;
endpackage : hres_pkg

//--- src/hres_event_status.sv
/*
  Latched receiver event status with write-one-to-clear controls and two
  maskable level interrupt lines.
  Assumes all event inputs come from logic on I_MCLK (no synchronisers),
  and a simple register port with read data one cycle after the strobe.
*/
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module hres_event_status
  import hres_pkg::*;
(
  input  wire logic              I_MCLK,
  input  wire logic              I_RSTN,
  input  wire logic [AW-1:0]     I_ADDR,
  input  wire logic [DW-1:0]     I_WDATA,
  input  wire logic              I_WR,
  input  wire logic              I_RD,
  output logic      [DW-1:0]     O_RDATA,
  input  wire hres_pulse_s       I_EVT_PULSE,
  input  wire hres_level_s       I_EVT_LEVEL,
  input  wire logic [FW-1:0]     I_LINK_FREQ,
  input  wire logic              I_LINK_FREQ_VALID,
  input  wire logic [DW-1:0]     I_AUDIO_BUFFER_LEVEL,
  output logic                   O_IRQ_LINE_ONE,
  output logic                   O_IRQ_LINE_TWO
);

  // latch set, clear, hold: a set in the clear cycle survives
  function automatic logic [DW-1:0] hres_merge(input logic [DW-1:0] cur,
                                               input logic [DW-1:0] set,
                                               input logic [DW-1:0] clr);
    hres_merge = (cur & ~clr) | set;
  endfunction : hres_merge

  // one strobe aimed at one register address; shared by every write decode
  function automatic logic hres_hit(input logic          strobe,
                                    input logic [AW-1:0] addr,
                                    input logic [AW-1:0] target);
    hres_hit = strobe && (addr == target);
  endfunction : hres_hit

  logic              rst_meta_reg;
  logic              rst_n;
  logic [DW-1:0]     status_three_reg;
  logic [DW-1:0]     status_four_reg;
  logic [DW-1:0]     mask1_three_reg;
  logic [DW-1:0]     mask2_three_reg;
  logic [DW-1:0]     mask1_four_reg;
  logic [DW-1:0]     mask2_four_reg;
  logic [DW-1:0]     freq_tol_reg;
  logic [DW-1:0]     low_thresh_reg;
  logic [FW-1:0]     freq_ref_reg;
  logic              freq_ref_ok_reg;
  hres_level_s       level_prev_reg;
  logic              level_ok_reg;
  logic              buffer_low_prev_reg;
  logic [DW-1:0]     rdata_reg;
  logic [DW-1:0]     set_three;
  logic [DW-1:0]     set_four;
  logic [DW-1:0]     clr_three;
  logic [DW-1:0]     clr_four;
  logic [FW-1:0]     freq_diff;
  logic              freq_moved;
  logic              buffer_low_now;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // previous levels; first sample after reset only primes the compare
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      level_prev_reg <= '0;
      level_ok_reg   <= 1'b0;
    end else begin
      level_prev_reg <= I_EVT_LEVEL;
      level_ok_reg   <= 1'b1;
    end
  end

  // frequency reference follows each accepted move
  always_comb begin
    if (I_LINK_FREQ >= freq_ref_reg) begin
      freq_diff = I_LINK_FREQ - freq_ref_reg;
    end else begin
      freq_diff = freq_ref_reg - I_LINK_FREQ;
    end
    freq_moved = I_LINK_FREQ_VALID && freq_ref_ok_reg
                 && (freq_diff > {{(FW-DW){1'b0}}, freq_tol_reg});
  end

  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      freq_ref_reg    <= RST_FREQ_REF;
      freq_ref_ok_reg <= 1'b0;
    end else if (I_LINK_FREQ_VALID && (!freq_ref_ok_reg || freq_moved)) begin
      freq_ref_reg    <= I_LINK_FREQ;
      freq_ref_ok_reg <= 1'b1;
    end
  end

  // low threshold crossing; edge only, a full drain sets it once
  assign buffer_low_now = (I_AUDIO_BUFFER_LEVEL <= low_thresh_reg);

  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      buffer_low_prev_reg <= 1'b0;
    end else begin
      buffer_low_prev_reg <= buffer_low_now;
    end
  end

  // event set vectors
  always_comb begin
    set_three = RST_ZERO;
    set_four  = RST_ZERO;
    set_three[B3_COLOR_DEPTH] = level_ok_reg
      && (I_EVT_LEVEL.color_depth != level_prev_reg.color_depth);
    set_three[B3_VIDEO_CLOCK] = I_EVT_PULSE.video_clock_irregular;
    set_three[B3_AUDIO_KIND]  = level_ok_reg
      && (I_EVT_LEVEL.audio_kind != level_prev_reg.audio_kind);
    set_three[B3_PARITY]      = I_EVT_PULSE.audio_parity_fail;
    set_three[B3_SAMPLE_RATE] = level_ok_reg
      && (I_EVT_LEVEL.sample_rate != level_prev_reg.sample_rate);
    set_three[B3_FLATLINE]    = I_EVT_PULSE.flatline_packet;
    set_three[B3_LINK_FREQ]   = freq_moved;
    set_three[B3_BUFFER_LOW]  = buffer_low_now && !buffer_low_prev_reg;
    set_four[B4_MPEG_CKS]     = I_EVT_PULSE.mpeg_frame_checksum;
    set_four[B4_PRODUCT_CKS]  = I_EVT_PULSE.product_frame_checksum;
    set_four[B4_AUDIO_CKS]    = I_EVT_PULSE.audio_frame_checksum;
    set_four[B4_VIDEO_CKS]    = I_EVT_PULSE.video_frame_checksum;
    set_four[B4_PORT_B_EXP]   = I_EVT_PULSE.port_b_integrity_expiry;
    set_four[B4_PORT_A_EXP]   = I_EVT_PULSE.port_a_integrity_expiry;
  end

  // clear controls act only during their write, nothing is stored
  always_comb begin
    clr_three = RST_ZERO;
    clr_four  = RST_ZERO;
    if (hres_hit(I_WR, I_ADDR, ADDR_CLEAR_THREE)) begin
      clr_three = I_WDATA;
    end
    if (hres_hit(I_WR, I_ADDR, ADDR_CLEAR_FOUR)) begin
      clr_four = I_WDATA & FOUR_LIVE_MASK;
    end
  end

  // latched status three; writes to its address are ignored
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      status_three_reg <= RST_ZERO;
    end else begin
      status_three_reg <= hres_merge(status_three_reg, set_three, clr_three);
    end
  end

  // latched status four; bits 1:0 have no source here and stay zero
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      status_four_reg <= RST_ZERO;
    end else begin
      status_four_reg <= hres_merge(status_four_reg, set_four, clr_four);
    end
  end

  // line one mask, status three
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      mask1_three_reg <= RST_ZERO;
    end else if (hres_hit(I_WR, I_ADDR, ADDR_MASK1_THREE)) begin
      mask1_three_reg <= I_WDATA;
    end
  end

  // line two mask, status three
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      mask2_three_reg <= RST_ZERO;
    end else if (hres_hit(I_WR, I_ADDR, ADDR_MASK2_THREE)) begin
      mask2_three_reg <= I_WDATA;
    end
  end

  // line one mask, status four; dead bits forced low so they never gate
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      mask1_four_reg <= RST_ZERO;
    end else if (hres_hit(I_WR, I_ADDR, ADDR_MASK1_FOUR)) begin
      mask1_four_reg <= I_WDATA & FOUR_LIVE_MASK;
    end
  end

  // line two mask, status four
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      mask2_four_reg <= RST_ZERO;
    end else if (hres_hit(I_WR, I_ADDR, ADDR_MASK2_FOUR)) begin
      mask2_four_reg <= I_WDATA & FOUR_LIVE_MASK;
    end
  end

  // frequency tolerance; a change only affects later measurements
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      freq_tol_reg <= RST_FREQ_TOL;
    end else if (hres_hit(I_WR, I_ADDR, ADDR_FREQ_TOL)) begin
      freq_tol_reg <= I_WDATA;
    end
  end

  // buffer low threshold; raising it past the level counts as an entry
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      low_thresh_reg <= RST_LOW_THRESH;
    end else if (hres_hit(I_WR, I_ADDR, ADDR_LOW_THRESH)) begin
      low_thresh_reg <= I_WDATA;
    end
  end

  // read data one cycle after the strobe, unmapped reads give zero
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= RST_ZERO;
    end else if (I_RD) begin
      case (I_ADDR)
        ADDR_STATUS_THREE: rdata_reg <= status_three_reg;
        ADDR_MASK1_THREE:  rdata_reg <= mask1_three_reg;
        ADDR_MASK2_THREE:  rdata_reg <= mask2_three_reg;
        ADDR_STATUS_FOUR:  rdata_reg <= status_four_reg;
        ADDR_MASK1_FOUR:   rdata_reg <= mask1_four_reg;
        ADDR_MASK2_FOUR:   rdata_reg <= mask2_four_reg;
        ADDR_FREQ_TOL:     rdata_reg <= freq_tol_reg;
        ADDR_LOW_THRESH:   rdata_reg <= low_thresh_reg;
        default:           rdata_reg <= RST_ZERO;
      endcase
    end else begin
      rdata_reg <= RST_ZERO;
    end
  end

  assign O_RDATA = rdata_reg;

  // bits only reach a line through that line's mask
  assign O_IRQ_LINE_ONE = |(status_three_reg & mask1_three_reg)
                        | |(status_four_reg & mask1_four_reg);
  assign O_IRQ_LINE_TWO = |(status_three_reg & mask2_three_reg)
                        | |(status_four_reg & mask2_four_reg);

endmodule : hres_event_status

//--- verification/hres_event_status_asserts.sv
/* checker for the latched event status block
   assumes binding onto hres_event_status, one clock */
`timescale 1ns/1ps
module hres_chk
  import hres_pkg::*;
(
  input wire logic          I_MCLK,
  input wire logic          I_RSTN,
  input wire logic [AW-1:0] I_ADDR,
  input wire logic [DW-1:0] I_WDATA,
  input wire logic          I_WR,
  input wire logic          I_RD,
  input wire logic [DW-1:0] O_RDATA,
  input wire hres_pulse_s   I_EVT_PULSE,
  input wire hres_level_s   I_EVT_LEVEL,
  input wire logic [FW-1:0] I_LINK_FREQ,
  input wire logic          I_LINK_FREQ_VALID,
  input wire logic [DW-1:0] I_AUDIO_BUFFER_LEVEL,
  input wire logic          O_IRQ_LINE_ONE,
  input wire logic          O_IRQ_LINE_TWO
);
  logic [3:0] up_reg;
  logic       mapped;
  // internal reset lags the pin, and level priming takes one more cycle
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) up_reg <= 4'h0;
    else up_reg <= {up_reg[2:0], 1'b1};
  end
  assign mapped = I_ADDR inside {ADDR_STATUS_THREE, ADDR_CLEAR_THREE, ADDR_MASK1_THREE, ADDR_MASK2_THREE,
    ADDR_STATUS_FOUR, ADDR_CLEAR_FOUR, ADDR_MASK1_FOUR, ADDR_MASK2_FOUR, ADDR_FREQ_TOL, ADDR_LOW_THRESH};
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);
  parity_set_a: assert property (up_reg[3] && I_EVT_PULSE.audio_parity_fail
    ##1 I_RD && I_ADDR == ADDR_STATUS_THREE |=> O_RDATA[B3_PARITY]) else $error("parity bit not latched");
  expiry_set_a: assert property (up_reg[3] && I_EVT_PULSE.port_a_integrity_expiry ##1 !I_WR
    ##1 I_RD && I_ADDR == ADDR_STATUS_FOUR |=> O_RDATA[B4_PORT_A_EXP]) else $error("expiry bit not latched");
  depth_change_a: assert property (up_reg[3] && I_EVT_LEVEL.color_depth != $past(I_EVT_LEVEL.color_depth)
    ##1 I_RD && I_ADDR == ADDR_STATUS_THREE |=> O_RDATA[B3_COLOR_DEPTH]) else $error("depth bit not latched");
  clear_bit_a: assert property (I_WR && I_ADDR == ADDR_CLEAR_THREE && I_WDATA[B3_PARITY]
    && !I_EVT_PULSE.audio_parity_fail ##1 I_RD && I_ADDR == ADDR_STATUS_THREE |=> !O_RDATA[B3_PARITY])
    else $error("parity bit not cleared");
  idle_rdata_a: assert property (!I_RD |=> O_RDATA == RST_ZERO) else $error("read data outside read");
  unmapped_zero_a: assert property (I_RD && !mapped |=> O_RDATA == RST_ZERO) else $error("unmapped read");
  four_low_a: assert property (I_RD && I_ADDR == ADDR_STATUS_FOUR |=> O_RDATA[1:0] == 2'b00)
    else $error("status four low bits set");
  irq_one_hold_a: assert property (O_IRQ_LINE_ONE && !I_WR |=> O_IRQ_LINE_ONE) else $error("line one dropped");
  irq_two_hold_a: assert property (O_IRQ_LINE_TWO && !I_WR |=> O_IRQ_LINE_TWO) else $error("line two dropped");
  cover property ($rose(O_IRQ_LINE_ONE));
  cover property ($rose(O_IRQ_LINE_TWO));
  cover property (I_WR && I_ADDR == ADDR_CLEAR_FOUR);
endmodule : hres_chk

bind hres_event_status hres_chk u_chk (.I_MCLK(I_MCLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_EVT_PULSE(I_EVT_PULSE), .I_EVT_LEVEL(I_EVT_LEVEL),
  .I_LINK_FREQ(I_LINK_FREQ), .I_LINK_FREQ_VALID(I_LINK_FREQ_VALID), .I_AUDIO_BUFFER_LEVEL(I_AUDIO_BUFFER_LEVEL),
  .O_IRQ_LINE_ONE(O_IRQ_LINE_ONE), .O_IRQ_LINE_TWO(O_IRQ_LINE_TWO));

//--- verification/tb.sv
/* self-checking bench for the latched event status block
   assumes the register port answers one cycle after the read strobe */
`timescale 1ns/1ps
module tb
  import hres_pkg::*;
;
  logic          mclk, rst_n, wr, rd, fvalid, irq1, irq2, rd_seen;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, blevel, rdata, e3, e4;
  logic [FW-1:0] freq, lf;
  hres_pulse_s   pulse, pend;
  hres_level_s   lvl;
  logic [DW-1:0] q[$];
  int            miscompares, check_count;
  logic [AW-1:0] ra [7] = '{ADDR_STATUS_THREE, ADDR_STATUS_FOUR, ADDR_CLEAR_THREE, ADDR_MASK2_FOUR,
                           ADDR_FREQ_TOL, ADDR_LOW_THRESH, 8'h00};
  logic [DW-1:0] rv [7] = '{RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_FREQ_TOL, RST_LOW_THRESH, RST_ZERO};

  hres_event_status dut (.I_MCLK(mclk), .I_RSTN(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_EVT_PULSE(pulse), .I_EVT_LEVEL(lvl), .I_LINK_FREQ(freq), .I_LINK_FREQ_VALID(fvalid),
    .I_AUDIO_BUFFER_LEVEL(blevel), .O_IRQ_LINE_ONE(irq1), .O_IRQ_LINE_TWO(irq2));

  // 50 ns clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one bus cycle; pending pulses ride along so each lasts one cycle
  task automatic bus(input logic w, input logic r, input logic [AW-1:0] a, input logic [DW-1:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    pulse <= pend;
    pend = '0;
    @(posedge mclk);
  endtask : bus

  task automatic rdq(input logic [AW-1:0] a, input logic [DW-1:0] e);
    q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask : rdq

  // lines settle after the edge that just passed
  task automatic irq_is(input logic l1, input logic l2);
    #1;
    chk({7'h00, irq1}, {7'h00, l1});
    chk({7'h00, irq2}, {7'h00, l2});
  endtask : irq_is

  task close_out;
    $display("miscompares %0d check_count %0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // read data is valid only in the cycle after the strobe
  always @(posedge mclk) begin
    if (rd_seen) chk(rdata, q.pop_front());
    rd_seen <= rd;
  end

  // hang guard, well beyond the fewer than one hundred cycles of the run
  initial begin
    #100us;
    miscompares++;
    close_out();
  end

  initial begin
    {wr, rd, fvalid, rd_seen, addr, wdata, freq, miscompares, check_count} = '0;
    {pulse, pend, lvl, e3, e4} = '0;
    rst_n = 1'b0;
    blevel = 8'hFF;
    lf = 16'h29E8;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) bus(1'b0, 1'b0, 8'h00, 8'h00);
    foreach (ra[i]) rdq(ra[i], rv[i]);
    bus(1'b1, 1'b0, ADDR_STATUS_THREE, 8'hFF);
    bus(1'b1, 1'b0, ADDR_STATUS_FOUR, 8'hFF);
    rdq(ADDR_STATUS_THREE, RST_ZERO);
    rdq(ADDR_STATUS_FOUR, RST_ZERO);
    // every pulse source in turn, bits accumulate
    for (int i = 0; i < 9; i++) begin
      pend = hres_pulse_s'(9'h001 << i);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      if (i > 5) e3[2*i-10] = 1'b1;
      else e4[i+2] = 1'b1;
      rdq(ADDR_STATUS_THREE, e3);
      rdq(ADDR_STATUS_FOUR, e4);
    end
    lf = lfsr(lf);
    lvl.color_depth <= lvl.color_depth ^ (lf[2:0] | 3'h1);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    e3[B3_COLOR_DEPTH] = 1'b1;
    rdq(ADDR_STATUS_THREE, e3);
    lvl.audio_kind <= lvl.audio_kind ^ (lf[4:3] | 2'h1);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    e3[B3_AUDIO_KIND] = 1'b1;
    rdq(ADDR_STATUS_THREE, e3);
    lvl.sample_rate <= lvl.sample_rate ^ (lf[8:5] | 4'h1);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    e3[B3_SAMPLE_RATE] = 1'b1;
    rdq(ADDR_STATUS_THREE, e3);
    // first measurement loads the reference, a move of exactly the tolerance is quiet
    freq <= {1'b0, lf[14:0]};
    fvalid <= 1'b1;
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    freq <= freq + 16'h0004;
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    fvalid <= 1'b0;
    rdq(ADDR_STATUS_THREE, e3);
    freq <= freq + 16'h0005;
    fvalid <= 1'b1;
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    fvalid <= 1'b0;
    e3[B3_LINK_FREQ] = 1'b1;
    rdq(ADDR_STATUS_THREE, e3);
    blevel <= RST_LOW_THRESH + 8'h01;
    rdq(ADDR_STATUS_THREE, e3);
    blevel <= RST_LOW_THRESH;
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    e3[B3_BUFFER_LOW] = 1'b1;
    rdq(ADDR_STATUS_THREE, e3);
    irq_is(1'b0, 1'b0);
    bus(1'b1, 1'b0, ADDR_MASK1_THREE, 8'h10);
    irq_is(1'b1, 1'b0);
    bus(1'b1, 1'b0, ADDR_MASK1_FOUR, 8'hFF);
    rdq(ADDR_MASK1_FOUR, FOUR_LIVE_MASK);
    bus(1'b1, 1'b0, ADDR_MASK1_FOUR, 8'h00);
    bus(1'b1, 1'b0, ADDR_MASK2_FOUR, 8'h04);
    irq_is(1'b1, 1'b1);
    bus(1'b1, 1'b0, ADDR_CLEAR_THREE, 8'h10);
    e3[B3_PARITY] = 1'b0;
    irq_is(1'b0, 1'b1);
    rdq(ADDR_STATUS_THREE, e3);
    pend.audio_parity_fail = 1'b1;
    bus(1'b1, 1'b0, ADDR_CLEAR_THREE, 8'h10);
    e3[B3_PARITY] = 1'b1;
    irq_is(1'b1, 1'b1);
    lf = lfsr(lf);
    bus(1'b1, 1'b0, ADDR_CLEAR_FOUR, lf[7:0]);
    e4 = e4 & ~lf[7:0];
    rdq(ADDR_STATUS_FOUR, e4);
    irq_is(1'b1, e4[B4_PORT_A_EXP]);
    bus(1'b1, 1'b0, ADDR_CLEAR_FOUR, 8'hFF);
    bus(1'b1, 1'b0, ADDR_CLEAR_THREE, 8'hFF);
    irq_is(1'b0, 1'b0);
    rdq(ADDR_STATUS_THREE, RST_ZERO);
    rdq(ADDR_STATUS_FOUR, RST_ZERO);
    // line two through status three; a threshold write alone makes the entry
    blevel <= 8'h20;
    bus(1'b1, 1'b0, ADDR_MASK2_THREE, 8'h01);
    rdq(ADDR_MASK2_THREE, 8'h01);
    irq_is(1'b0, 1'b0);
    bus(1'b1, 1'b0, ADDR_LOW_THRESH, 8'h30);
    rdq(ADDR_LOW_THRESH, 8'h30);
    rdq(ADDR_STATUS_THREE, 8'h01);
    irq_is(1'b0, 1'b1);
    bus(1'b1, 1'b0, ADDR_FREQ_TOL, 8'h10);
    rdq(ADDR_FREQ_TOL, 8'h10);
    repeat (3) bus(1'b0, 1'b0, 8'h00, 8'h00);
    close_out();
  end
endmodule : tb
